// ---- rtl/phu_pkg.sv ----
// Purpose: Shared constants and types of the polynomial hash unit
// Assumes: One 50 MHz clock, asynchronous active-low reset
// Notes:   Widths are encoded 0 = 48 bit, 1 = 64 bit, 2 = 128 bit
package phu_pkg;

   // Operand widths
   localparam logic [1:0]   W48            = 2'h0;
   localparam logic [1:0]   W64            = 2'h1;
   localparam logic [1:0]   W128           = 2'h2;

   // Generator polynomials without their top term
   localparam logic [127:0] GEN_48         = 128'h1002000401;
   localparam logic [127:0] GEN_64         = 128'h0040_0008_0002_0001;
   localparam logic [127:0] GEN_128        = 128'h0000_0004_0000_0020_0000_0002_0000_0001;
   localparam logic [127:0] MASK_48        = 128'hffff_ffff_ffff;
   localparam logic [127:0] MASK_64        = 128'hffff_ffff_ffff_ffff;
   localparam logic [127:0] MASK_128       = {128{1'b1}};

   // Transfer words and array steps per operand
   localparam logic [2:0]   WORDS_SHORT    = 3'h2;
   localparam logic [2:0]   WORDS_LONG     = 3'h4;
   localparam logic [3:0]   STEPS_48       = 4'h3;
   localparam logic [3:0]   STEPS_64       = 4'h4;
   localparam logic [3:0]   STEPS_128      = 4'h8;
   localparam logic [1:0]   MAX_OPS        = 2'h3;
   localparam logic [1:0]   QUEUE_DEPTH    = 2'h3;
   localparam int           BUF_WORDS      = 12;

   // Core operand/result and multiplier word map
   localparam logic [3:0]   ADDR_48_LAST   = 4'h1;
   localparam logic [3:0]   ADDR_64_BASE   = 4'h2;
   localparam logic [3:0]   ADDR_64_LAST   = 4'h3;
   localparam logic [3:0]   ADDR_128_BASE  = 4'h4;
   localparam logic [3:0]   ADDR_128_LAST  = 4'h7;
   localparam logic [3:0]   ADDR_DONE      = 4'h8;

   // Multiplier reset value and done read value
   localparam logic [127:0] MULT_RESET     = 128'h1;
   localparam logic [31:0]  DONE_SET       = 32'h1;

   typedef enum logic [3:0]
   {
      ST_IDLE = 4'b0001,
      ST_LOAD = 4'b0010,
      ST_HASH = 4'b0100,
      ST_SPARE = 4'b1000
   } phu_state_t;

endpackage

// ---- rtl/phu_hash_step.sv ----
// Purpose: One hash array step: sixteen operand bits through multiply and divide
// Assumes: Accumulator already reduced below the generator order
// Notes:   Purely combinational; the caller registers the result
`timescale 1ns/1ns
module phu_hash_step
(
   // Array inputs
   input  wire logic [127:0] i_acc,
   input  wire logic [127:0] i_mult,
   input  wire logic [15:0]  i_chunk,
   input  wire logic [1:0]   i_width,
   // Array output
   output logic      [127:0] o_acc
);

   function automatic logic [127:0] width_mask(input logic [1:0] w);
      width_mask = (w == phu_pkg::W48) ? phu_pkg::MASK_48 :
                   (w == phu_pkg::W64) ? phu_pkg::MASK_64 : phu_pkg::MASK_128;
   endfunction

   // Multiply by x, reduce by the generator
   function automatic logic [127:0] mul_x(input logic [127:0] v, input logic [1:0] w);
      logic top;
      logic [127:0] sh;
      top = (w == phu_pkg::W48) ? v[47] : (w == phu_pkg::W64) ? v[63] : v[127];
      sh  = {v[126:0], 1'b0} & width_mask(w);
      if (top)
      begin
         sh = sh ^ ((w == phu_pkg::W48) ? phu_pkg::GEN_48 :
                    (w == phu_pkg::W64) ? phu_pkg::GEN_64 : phu_pkg::GEN_128);
      end
      mul_x = sh;
   endfunction

   // Horner form, highest bit first: acc = acc*x^16 + chunk*M mod G
   always_comb
   begin
      logic [127:0] a;
      logic [127:0] m;
      a = i_acc;
      m = i_mult & width_mask(i_width);
      for (int b = 15; b >= 0; b--)
      begin
         a = mul_x(a, i_width) ^ (i_chunk[b] ? m : 128'h0);
      end
      o_acc = a;
   end

endmodule // phu_hash_step

// ---- rtl/phu_hash_unit.sv ----
// Purpose: Polynomial hash engine with command, pull, push and core gasket ports
// Assumes: Partners run on i_clk; core holds a read until acknowledged
// Notes:   Core commands take priority over engine commands when both wait
//
// What this block does
// - Hash 48, 64 and 128 bit operands into same-width indexes.
// - One engine command carries one to three operands of one width.
// - For 48-bit operands the upper half of word two is ignored.
// - Results return in order to the words that supplied operands.
// - Core operand groups per width; writing the last word issues the command.
// - At most one core hash of each width outstanding.
// - Whole operand burst is buffered; first hashes while others queue.
// - One multiplier per width, loaded as two or four words.
// - Operand enters the array 16 bits per step: 3, 4 or 8 steps.
// - Each step multiplies and divides, partial result fed back.
// - Finished index goes to output queue; next operand starts at once.
// - Each engine index raises a push request, moved out on grant.
// - Core reads results at the operand addresses.
// - Done clears on operand write, sets when the result arrives.
// - Core result read is held until the result is valid.
// - Latency is input cycles plus array steps plus output cycles.
// - Bit i of operand and multiplier is the x^i coefficient.
// - Index is the carry-less product modulo the generator.
// - 48-bit generator has terms at powers 0, 10, 25, 36, 48.
// - 64-bit generator has terms at powers 0, 17, 35, 54, 64.
// - 128-bit generator has terms at powers 0, 33, 69, 98, 128.
`timescale 1ns/1ns
module phu_hash_unit
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   // Engine command
   input  wire logic        i_cmd_valid,
   input  wire logic [1:0]  i_cmd_width,
   input  wire logic [1:0]  i_cmd_count,
   output logic             o_cmd_ready,
   // Pull data
   input  wire logic        i_pull_valid,
   input  wire logic [31:0] i_pull_data,
   output logic             o_pull_ready,
   // Push data
   output logic             o_push_req,
   output logic [31:0]      o_push_data,
   input  wire logic        i_push_grant,
   // Multiplier load
   input  wire logic        i_mult_wr,
   input  wire logic [3:0]  i_mult_addr,
   input  wire logic [31:0] i_mult_data,
   // Core gasket
   input  wire logic        i_core_wr,
   input  wire logic        i_core_rd,
   input  wire logic [3:0]  i_core_addr,
   input  wire logic [31:0] i_core_wdata,
   output logic             o_core_ack,
   output logic [31:0]      o_core_rdata,
   output logic             o_core_done
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed
   {
      phu_pkg::phu_state_t    state;
      logic                   cmd_ready;
      logic                   pull_ready;
      logic [1:0]             cmd_w;
      logic [1:0]             cmd_n;
      logic                   cmd_core;
      logic [3:0]             ld_cnt;
      logic [1:0]             op_idx;
      logic [3:0]             step;
      logic [127:0]           acc;
      logic [11:0][31:0]      buf_w;
      logic [2:0][127:0]      q_data;
      logic [2:0][1:0]        q_w;
      logic [2:0]             q_core;
      logic [1:0]             q_head;
      logic [1:0]             q_tail;
      logic [1:0]             q_cnt;
      logic [1:0]             word_idx;
      logic                   push_req;
      logic [31:0]            push_data;
      logic [2:0][127:0]      mult;
      logic [2:0][127:0]      core_op;
      logic [2:0][127:0]      core_res;
      logic [2:0]             core_busy;
      logic [2:0]             core_pend;
      logic [2:0]             core_valid;
      logic                   done;
      logic                   core_ack;
      logic [31:0]            core_rdata;
   } phu_regs_t;

   phu_regs_t                 r;
   phu_regs_t                 next_r;
   logic [127:0]              step_acc;
   logic [127:0]              operand;
   logic [15:0]               chunk;
   logic [127:0]              step_mult;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [2:0] words_of(input logic [1:0] w);
      words_of = (w == phu_pkg::W128) ? phu_pkg::WORDS_LONG : phu_pkg::WORDS_SHORT;
   endfunction

   function automatic logic [3:0] steps_of(input logic [1:0] w);
      steps_of = (w == phu_pkg::W48) ? phu_pkg::STEPS_48 :
                 (w == phu_pkg::W64) ? phu_pkg::STEPS_64 : phu_pkg::STEPS_128;
   endfunction

   function automatic logic [1:0] addr_width(input logic [3:0] a);
      addr_width = (a <= phu_pkg::ADDR_48_LAST) ? phu_pkg::W48 :
                   (a <= phu_pkg::ADDR_64_LAST) ? phu_pkg::W64 : phu_pkg::W128;
   endfunction

   function automatic logic [1:0] addr_word(input logic [3:0] a);
      logic [3:0] d;
      d = (a <= phu_pkg::ADDR_48_LAST) ? a :
          (a <= phu_pkg::ADDR_64_LAST) ? a - phu_pkg::ADDR_64_BASE : a - phu_pkg::ADDR_128_BASE;
      addr_word = d[1:0];
   endfunction

   function automatic logic addr_last(input logic [3:0] a);
      addr_last = (a == phu_pkg::ADDR_48_LAST) || (a == phu_pkg::ADDR_64_LAST) ||
                  (a == phu_pkg::ADDR_128_LAST);
   endfunction

   // Upper 16 bits of the second word are dropped for 48-bit operands
   function automatic logic [127:0] trim(input logic [127:0] v, input logic [1:0] w);
      trim = (w == phu_pkg::W48) ? (v & phu_pkg::MASK_48) :
             (w == phu_pkg::W64) ? (v & phu_pkg::MASK_64) : v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Operand selection and hash array

   always_comb
   begin
      logic [3:0]   base;
      logic [127:0] raw;
      logic [3:0]   ci;
      logic [127:0] shifted;
      base = 4'(r.op_idx * words_of(r.cmd_w));
      raw  = {r.buf_w[4'(base + 4'h3)], r.buf_w[4'(base + 4'h2)],
              r.buf_w[4'(base + 4'h1)], r.buf_w[base]};
      if (r.cmd_core)
      begin
         raw = r.core_op[r.cmd_w];
      end
      operand = trim(raw, r.cmd_w);
      // Highest chunk first, so the feedback acts as Horner's rule
      ci      = 4'(steps_of(r.cmd_w) - 4'h1 - r.step);
      shifted = operand >> {ci, 4'h0};
      chunk   = shifted[15:0];
      step_mult = r.mult[r.cmd_w];
   end

   phu_hash_step u_step
   (
      .i_acc   ((r.step == 4'h0) ? 128'h0 : r.acc),
      .i_mult  (step_mult),
      .i_chunk (chunk),
      .i_width (r.cmd_w),
      .o_acc   (step_acc)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      logic       enq;
      logic       deq;
      logic       take;
      logic [1:0] hw;
      logic [1:0] hx;
      logic [3:0] total;
      next_r          = r;
      enq             = 1'b0;
      deq             = 1'b0;
      next_r.core_ack = 1'b0;
      hw = addr_width(i_core_addr);
      hx = addr_word(i_core_addr);
      total = 4'(r.cmd_n * words_of(r.cmd_w));

      // Multiplier words
      if (i_mult_wr && i_mult_addr < phu_pkg::ADDR_DONE)
      begin
         next_r.mult[addr_width(i_mult_addr)][{addr_word(i_mult_addr), 5'h0} +: 32] =
            i_mult_data;
      end

      // Core operand writes; a busy width ignores them
      if (i_core_wr && i_core_addr < phu_pkg::ADDR_DONE && !r.core_busy[hw])
      begin
         next_r.core_op[hw][{hx, 5'h0} +: 32] = i_core_wdata;
         next_r.done           = 1'b0;
         next_r.core_valid[hw] = 1'b0;
         if (addr_last(i_core_addr))
         begin
            next_r.core_pend[hw] = 1'b1;
            next_r.core_busy[hw] = 1'b1;
         end
      end

      // Core reads; a result read waits for a valid result
      if (i_core_rd && !r.core_ack)
      begin
         if (i_core_addr == phu_pkg::ADDR_DONE)
         begin
            next_r.core_ack   = 1'b1;
            next_r.core_rdata = r.done ? phu_pkg::DONE_SET : 32'h0;
         end
         else if (i_core_addr > phu_pkg::ADDR_DONE)
         begin
            next_r.core_ack   = 1'b1;
            next_r.core_rdata = 32'h0;
         end
         else if (r.core_valid[hw])
         begin
            next_r.core_ack   = 1'b1;
            next_r.core_rdata = r.core_res[hw][{hx, 5'h0} +: 32];
         end
      end

      case (r.state)
         phu_pkg::ST_IDLE:
         begin
            next_r.step   = 4'h0;
            next_r.op_idx = 2'h0;
            next_r.ld_cnt = 4'h0;
            if (i_cmd_valid && r.cmd_ready && |i_cmd_count && i_cmd_count <= phu_pkg::MAX_OPS)
            begin
               next_r.cmd_w = (i_cmd_width > phu_pkg::W128) ? phu_pkg::W128 : i_cmd_width;
               next_r.cmd_n    = i_cmd_count;
               next_r.cmd_core = 1'b0;
               next_r.state    = phu_pkg::ST_LOAD;
            end
            else if (r.core_pend != 3'h0)
            begin
               next_r.cmd_w    = r.core_pend[0] ? phu_pkg::W48 :
                                 r.core_pend[1] ? phu_pkg::W64 : phu_pkg::W128;
               next_r.cmd_n    = 2'h1;
               next_r.cmd_core = 1'b1;
               next_r.core_pend[next_r.cmd_w] = 1'b0;
               next_r.state    = phu_pkg::ST_HASH;
            end
         end
         phu_pkg::ST_LOAD:
         begin
            // Whole burst lands in the buffer before hashing starts
            if (i_pull_valid && r.pull_ready)
            begin
               next_r.buf_w[r.ld_cnt] = i_pull_data;
               next_r.ld_cnt = 4'(r.ld_cnt + 4'h1);
               if (4'(r.ld_cnt + 4'h1) == total)
               begin
                  next_r.state = phu_pkg::ST_HASH;
               end
            end
         end
         phu_pkg::ST_HASH:
         begin
            if (r.step != 4'(steps_of(r.cmd_w) - 4'h1))
            begin
               next_r.acc  = step_acc;
               next_r.step = 4'(r.step + 4'h1);
            end
            else if (r.q_cnt != phu_pkg::QUEUE_DEPTH)
            begin
               // A full queue stalls the array on its last step
               enq = 1'b1;
               next_r.q_data[r.q_tail] = step_acc;
               next_r.q_w[r.q_tail]    = r.cmd_w;
               next_r.q_core[r.q_tail] = r.cmd_core;
               next_r.q_tail = (r.q_tail == 2'h2) ? 2'h0 : 2'(r.q_tail + 2'h1);
               next_r.step   = 4'h0;
               next_r.acc    = 128'h0;
               next_r.op_idx = 2'(r.op_idx + 2'h1);
               if (2'(r.op_idx + 2'h1) == r.cmd_n)
               begin
                  next_r.state = phu_pkg::ST_IDLE;
               end
            end
         end
         default:
         begin
            next_r.state = phu_pkg::ST_IDLE;
         end
      endcase

      // Output queue drains in order: core results to the gasket, the rest pushed
      take = !r.push_req || i_push_grant;
      if (take)
      begin
         next_r.push_req = 1'b0;
      end
      if (r.q_cnt != 2'h0)
      begin
         if (r.q_core[r.q_head])
         begin
            deq = 1'b1;
            next_r.core_res[r.q_w[r.q_head]]   = r.q_data[r.q_head];
            next_r.core_valid[r.q_w[r.q_head]] = 1'b1;
            next_r.core_busy[r.q_w[r.q_head]]  = 1'b0;
            next_r.done = 1'b1;
         end
         else if (take)
         begin
            next_r.push_req  = 1'b1;
            next_r.push_data = r.q_data[r.q_head][{r.word_idx, 5'h0} +: 32];
            next_r.word_idx  = 2'(r.word_idx + 2'h1);
            if (({1'b0, r.word_idx} + 3'h1) == words_of(r.q_w[r.q_head]))
            begin
               deq = 1'b1;
               next_r.word_idx = 2'h0;
            end
         end
      end
      if (deq)
      begin
         next_r.q_head = (r.q_head == 2'h2) ? 2'h0 : 2'(r.q_head + 2'h1);
      end
      next_r.q_cnt = 2'(r.q_cnt + {1'b0, enq} - {1'b0, deq});

      next_r.cmd_ready  = (next_r.state == phu_pkg::ST_IDLE) && (next_r.core_pend == 3'h0);
      next_r.pull_ready = (next_r.state == phu_pkg::ST_LOAD);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         r            <= '0;
         r.state      <= phu_pkg::ST_IDLE;
         r.mult       <= {3{phu_pkg::MULT_RESET}};
      end
      else
      begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_cmd_ready  = r.cmd_ready;
   assign o_pull_ready = r.pull_ready;
   assign o_push_req   = r.push_req;
   assign o_push_data  = r.push_data;
   assign o_core_ack   = r.core_ack;
   assign o_core_rdata = r.core_rdata;
   assign o_core_done  = r.done;

endmodule // phu_hash_unit

// ---- testbench/phu_hash_asserts.sv ----
// Purpose: Port assertions for the polynomial hash unit
// Assumes: Bound to phu_hash_unit, one clock domain
// Notes:   Watches what the design drives and the inputs that qualify it
`timescale 1ns/1ns
module phu_hash_asserts
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   // Watched ports
   input  wire logic        i_cmd_valid,
   input  wire logic [1:0]  i_cmd_count,
   input  wire logic        o_cmd_ready,
   input  wire logic        o_pull_ready,
   input  wire logic        o_push_req,
   input  wire logic [31:0] o_push_data,
   input  wire logic        i_push_grant,
   input  wire logic        i_core_rd,
   input  wire logic [3:0]  i_core_addr,
   input  wire logic        o_core_ack,
   input  wire logic [31:0] o_core_rdata
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   a_push_hold: assert property (o_push_req && !i_push_grant |=>
      o_push_req && $stable(o_push_data)) else $error("push word changed before grant");
   a_ack_cause: assert property (o_core_ack |-> $past(i_core_rd))
      else $error("core ack without a read");
   a_cmd_take: assert property (i_cmd_valid && o_cmd_ready && i_cmd_count != 2'h0 |=>
      !o_cmd_ready && o_pull_ready) else $error("command not taken into loading");
   a_zero_refused: assert property (i_cmd_valid && i_cmd_count == 2'h0 && !o_pull_ready
      |=> !o_pull_ready) else $error("zero operand command taken");
   a_pull_excl: assert property (o_pull_ready |-> !o_cmd_ready)
      else $error("ready for command while loading");
   a_done_read: assert property ($rose(i_core_rd) && i_core_addr == phu_pkg::ADDR_DONE
      |-> ##[1:3] (o_core_ack && o_core_rdata[31:1] == 31'h0)) else $error("bad done read");
   a_push_soon: assert property ($fell(o_pull_ready) |-> ##[3:80] o_push_req)
      else $error("no index pushed after loading");
   a_ready_back: assert property ($fell(o_pull_ready) |-> ##[1:1000] o_cmd_ready)
      else $error("engine never ready again");
endmodule // phu_hash_asserts

bind phu_hash_unit phu_hash_asserts phu_hash_asserts_inst (.i_clk, .i_reset_n, .i_cmd_valid,
   .i_cmd_count, .o_cmd_ready, .o_pull_ready, .o_push_req, .o_push_data, .i_push_grant,
   .i_core_rd, .i_core_addr, .o_core_ack, .o_core_rdata);

// ---- testbench/phu_push_partner.sv ----
// Purpose: Scratchpad push arbiter model granting hash index words
// Assumes: Grant sampled with request at the rising edge
// Notes:   Slow mode grants one cycle in four to stretch held requests
`timescale 1ns/1ns
module phu_push_partner
(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset_n,
   // Push handshake
   input  wire logic i_push_req,
   input  wire logic i_slow,
   output logic      o_push_grant
);
   logic [1:0] pace;

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pace         <= 2'h0;
         o_push_grant <= 1'b0;
      end
      else
      begin
         pace         <= pace + 2'h1;
         o_push_grant <= i_push_req && (!i_slow || pace == 2'h0);
      end
   end
endmodule // phu_push_partner

// ---- testbench/tb_phu_hash_unit.sv ----
// Purpose: Self-checking bench for the polynomial hash unit
// Assumes: Multipliers reset to one; core address map as in the package
// Notes:   Reference generators built from powers, not from package masks
`timescale 1ns/1ns
module tb_phu_hash_unit;
   logic         i_clk = 1'b0;
   logic         i_reset_n = 1'b0;
   logic         i_cmd_valid = 1'b0;
   logic [1:0]   i_cmd_width = 2'h0;
   logic [1:0]   i_cmd_count = 2'h0;
   logic         i_pull_valid = 1'b0;
   logic [31:0]  i_pull_data = 32'h0;
   logic         i_mult_wr = 1'b0;
   logic [3:0]   i_mult_addr = 4'h0;
   logic [31:0]  i_mult_data = 32'h0;
   logic         i_core_wr = 1'b0;
   logic         i_core_rd = 1'b0;
   logic [3:0]   i_core_addr = 4'h0;
   logic [31:0]  i_core_wdata = 32'h0;
   logic         slow = 1'b0;
   logic         o_cmd_ready, o_pull_ready, o_push_req, i_push_grant, o_core_ack, o_core_done;
   logic [31:0]  o_push_data, o_core_rdata;
   logic [31:0]  lfsr = 32'h28;
   logic [127:0] mult [3];
   logic [31:0]  got [$];
   logic [31:0]  exp [$];
   int           n_fail = 0;
   int           comparisons = 0;

   always #10 i_clk = ~i_clk;

   phu_hash_unit phu_hash_unit_inst (.i_clk, .i_reset_n, .i_cmd_valid, .i_cmd_width,
      .i_cmd_count, .o_cmd_ready, .i_pull_valid, .i_pull_data, .o_pull_ready, .o_push_req,
      .o_push_data, .i_push_grant, .i_mult_wr, .i_mult_addr, .i_mult_data, .i_core_wr,
      .i_core_rd, .i_core_addr, .i_core_wdata, .o_core_ack, .o_core_rdata, .o_core_done);
   phu_push_partner phu_push_partner_inst (.i_clk, .i_reset_n, .i_push_req(o_push_req),
      .i_slow(slow), .o_push_grant(i_push_grant));

   always @(posedge i_clk)
      if (o_push_req === 1'b1 && i_push_grant === 1'b1) got.push_back(o_push_data);

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction

   function automatic int nbits(input int w);
      return (w == 0) ? 48 : (w == 1) ? 64 : 128;
   endfunction

   // Horner over operand bits; bits above the width never enter
   function automatic logic [127:0] ref_hash(input logic [127:0] a, input int w);
      int           n;
      logic [128:0] g;
      logic [128:0] r;
      n = nbits(w);
      g = (129'h1 << n) | 129'h1;
      case (w)
         0: g |= (129'h1 << 10) | (129'h1 << 25) | (129'h1 << 36);
         1: g |= (129'h1 << 17) | (129'h1 << 35) | (129'h1 << 54);
         default: g |= (129'h1 << 33) | (129'h1 << 69) | (129'h1 << 98);
      endcase
      r = 129'h0;
      for (int i = n - 1; i >= 0; i--)
      begin
         r = r << 1;
         if (r[n]) r ^= g;
         if (a[i]) r ^= {1'b0, mult[w]};
      end
      return r[127:0];
   endfunction

   task automatic check(input logic [127:0] g, input logic [127:0] e);
      comparisons++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic run_cmd(input int w, input int n);
      logic [127:0] op;
      int           t;
      t = 0;
      i_cmd_width <= w[1:0];
      i_cmd_count <= n[1:0];
      i_cmd_valid <= 1'b1;
      do @(posedge i_clk); while (o_cmd_ready !== 1'b1 && t++ < 2000);
      check(o_cmd_ready, 1'b1);
      i_cmd_valid <= 1'b0;
      for (int k = 0; k < n; k++)
      begin
         op = {rnd(), rnd(), rnd(), rnd()};
         // Word two of a 48-bit operand carries random junk up top
         for (int j = 0; j < ((w == 2) ? 4 : 2); j++)
         begin
            i_pull_valid <= 1'b1;
            i_pull_data  <= op[32 * j +: 32];
            do @(posedge i_clk); while (o_pull_ready !== 1'b1 && t++ < 4000);
         end
         op = ref_hash(op, w);
         for (int j = 0; j < ((w == 2) ? 4 : 2); j++) exp.push_back(op[32 * j +: 32]);
      end
      i_pull_valid <= 1'b0;
      while (got.size() < exp.size() && t++ < 4000) @(posedge i_clk);
      while (exp.size() > 0) check(got.size() ? got.pop_front() : 'x, exp.pop_front());
      check(got.size(), 0);
   endtask

   task automatic load_mults();
      for (int w = 0; w < 3; w++)
      begin
         mult[w] = {rnd(), rnd(), rnd(), rnd()} & ({128{1'b1}} >> (128 - nbits(w)));
         for (int j = 0; j < ((w == 2) ? 4 : 2); j++)
         begin
            i_mult_wr   <= 1'b1;
            i_mult_addr <= 4'(2 * w + j);
            i_mult_data <= mult[w][32 * j +: 32];
            @(posedge i_clk);
         end
      end
      i_mult_wr <= 1'b0;
   endtask

   task automatic core_read(input logic [3:0] a, output logic [31:0] d);
      int t;
      t = 0;
      i_core_rd   <= 1'b1;
      i_core_addr <= a;
      do @(posedge i_clk); while (o_core_ack !== 1'b1 && t++ < 500);
      check(o_core_ack, 1'b1);
      d = o_core_rdata;
      i_core_rd <= 1'b0;
      repeat (2) @(posedge i_clk);
   endtask

   // Second group to a busy width must be dropped, so the first result stands
   task automatic core_op(input int w, input int groups);
      logic [127:0] op;
      logic [31:0]  d;
      op = {rnd(), rnd(), rnd(), rnd()};
      for (int p = 0; p < groups; p++)
         for (int j = 0; j < ((w == 2) ? 4 : 2); j++)
         begin
            i_core_wr    <= 1'b1;
            i_core_addr  <= 4'(2 * w + j);
            i_core_wdata <= op[32 * j +: 32] ^ {32{p[0]}};
            @(posedge i_clk);
         end
      i_core_wr <= 1'b0;
      @(posedge i_clk);
      check(o_core_done, 1'b0);
      d = 32'h0;
      for (int t = 0; t < 50 && w == 0 && d !== 32'h1; t++) core_read(phu_pkg::ADDR_DONE, d);
      if (w == 0) check(d, 32'h1);
      op = ref_hash(op, w);
      for (int j = 0; j < ((w == 2) ? 4 : 2); j++)
      begin
         core_read(4'(2 * w + j), d);
         check(d, op[32 * j +: 32]);
      end
      check(o_core_done, 1'b1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      foreach (mult[w]) mult[w] = 128'h1;
      repeat (10) @(posedge i_clk);
      i_reset_n <= 1'b1;
      repeat (2) @(posedge i_clk);
      for (int s = 0; s < 2; s++)
      begin
         for (int w = 0; w < 3; w++)
            for (int n = 1; n <= 3; n++) run_cmd(w, n);
         $display("test engine pass %0d done", s);
         load_mults();
         slow <= 1'b1;
      end
      i_cmd_count <= 2'h0;
      i_cmd_valid <= 1'b1;
      repeat (6) @(posedge i_clk);
      check(o_pull_ready, 1'b0);
      i_cmd_valid <= 1'b0;
      $display("test zero count done");
      core_op(0, 1);
      core_op(1, 2);
      core_op(2, 1);
      $display("test core gasket done");
      results();
   end

   initial
   begin
      repeat (50000) @(posedge i_clk);
      n_fail++;
      results();
   end
endmodule // tb_phu_hash_unit
